//--- bus_error_logger_pkg.sv
// Constants shared by the bus error status logger and its helpers.
// Assumes one core clock; every slower rate is an enable pulse.
`default_nettype none
package bus_error_logger_pkg;
    // ********************************************************************
    // Status register layout
    // ********************************************************************
    localparam int                 STATUS_W         = 64;
    localparam logic [63:0]        STATUS_RESET     = 64'h0000_0000_0000_0000;
    localparam int                 CLASS_LSB        = 25;
    localparam int                 CLASS_MSB        = 27;
    localparam int                 BIT_FRC          = 28;
    localparam int                 BIT_BUS_ERR      = 29;
    localparam int                 BIT_INT_INIT     = 30;
    localparam int                 BIT_EXT_INIT     = 35;
    localparam int                 BIT_RESP_PAR     = 36;
    localparam int                 BIT_SPLIT_HARD   = 37;
    localparam int                 BIT_STALL        = 38;
    localparam int                 BIT_HARD_ERR     = 42;
    localparam int                 BIT_INT_FAIL     = 43;
    localparam logic [63:0]        CLASS_MASK       = 64'h0000_0000_0E00_0000;
    localparam logic [63:0]        STICKY_MASK      = 64'h0000_0C78_7000_0000;
    localparam logic [63:0]        IMPL_MASK        = CLASS_MASK | STICKY_MASK;

    // ********************************************************************
    // Bus-queue error classes
    // ********************************************************************
    localparam logic [2:0]         HARD_ERROR_CLASS         = 3'h0;
    localparam logic [2:0]         DOUBLE_ERROR_CLASS       = 3'h1;
    localparam logic [2:0]         SECOND_ADDR_PARITY_CLASS = 3'h2;
    localparam logic [2:0]         SINGLE_ERROR_CLASS       = 3'h4;
    localparam logic [2:0]         FIRST_ADDR_PARITY_CLASS  = 3'h5;

    // ********************************************************************
    // Response codes and link timing
    // ********************************************************************
    localparam logic [2:0]         RESP_HARD_ERROR  = 3'h1;
    localparam int                 SYNC_W           = 6;
    localparam int                 OWN_DRIVE_W      = 4;
    localparam logic [3:0]         INIT_HOLD_CYCLES = 4'h8;

    // ********************************************************************
    // Stall watchdog
    // ********************************************************************
    localparam int                 PRESCALE_W       = 8;
    localparam logic [7:0]         PRESCALE_LAST    = 8'h7F;
    localparam int                 STALL_W          = 15;
    localparam logic [1:0]         RATIO_HALF       = 2'h0;
    localparam logic [1:0]         RATIO_THIRD      = 2'h1;
    localparam logic [1:0]         RATIO_QUARTER    = 2'h2;
    localparam logic [1:0]         RATIO_LAST_HALF  = 2'h1;
    localparam logic [1:0]         RATIO_LAST_THIRD = 2'h2;
    localparam logic [1:0]         RATIO_LAST_QUART = 2'h3;
endpackage
`default_nettype wire

//--- pin_sync.sv
// Three-stage synchroniser for a group of pins.
// Assumes the pins change asynchronously to mclk.
`default_nettype none
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] pins,
    input  wire logic [W-1:0] idle_value,
    output var  logic [W-1:0] stable
);
    logic [W-1:0] ff1_q;
    logic [W-1:0] ff2_q;
    logic [W-1:0] ff3_q;
    logic [W-1:0] stable_q;
    logic [W-1:0] stable_d;

    // A change is accepted once the second and third stages agree.
    always_comb begin
        stable_d = stable_q;
        if (ff2_q == ff3_q) begin
            stable_d = ff3_q;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ff1_q    <= '1;
            ff2_q    <= '1;
            ff3_q    <= '1;
            stable_q <= '1;
        end else begin
            ff1_q    <= pins;
            ff2_q    <= ff1_q;
            ff3_q    <= ff2_q;
            stable_q <= stable_d;
        end
    end

    // Until the first clock after reset the group reads idle.
    logic seen_q;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= 1'b1;
        end
    end

    assign stable = seen_q ? stable_q : idle_value;
endmodule
`default_nettype wire

//--- stall_watchdog.sv
// Retirement-stall watchdog: bus-clock enable, prescaler and stall counter.
// Assumes mclk is the core clock and the ratio input is static.
`default_nettype none
`timescale 1ns/1ns
module stall_watchdog (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic [1:0] bus_ratio,
    input  wire logic       clear,
    output var  logic       bus_tick,
    output var  logic       timeout
);
    logic [1:0]                                 ratio_q;
    logic [1:0]                                 ratio_d;
    logic [1:0]                                 ratio_last;
    logic [bus_error_logger_pkg::PRESCALE_W-1:0] pre_q;
    logic [bus_error_logger_pkg::PRESCALE_W-1:0] pre_d;
    logic [bus_error_logger_pkg::STALL_W-1:0]    stall_q;
    logic [bus_error_logger_pkg::STALL_W-1:0]    stall_d;
    logic                                       pre_carry;
    logic                                       stall_carry;

    always_comb begin
        case (bus_ratio)
            bus_error_logger_pkg::RATIO_HALF:    ratio_last = bus_error_logger_pkg::RATIO_LAST_HALF;
            bus_error_logger_pkg::RATIO_THIRD:   ratio_last = bus_error_logger_pkg::RATIO_LAST_THIRD;
            bus_error_logger_pkg::RATIO_QUARTER: ratio_last = bus_error_logger_pkg::RATIO_LAST_QUART;
            default:                             ratio_last = bus_error_logger_pkg::RATIO_LAST_QUART;
        endcase
        bus_tick = (ratio_q >= ratio_last);
        ratio_d  = bus_tick ? 2'h0 : ratio_q + 2'h1;
        pre_carry = bus_tick && (pre_q == bus_error_logger_pkg::PRESCALE_LAST);
        pre_d     = pre_q;
        if (bus_tick) begin
            pre_d = pre_carry ? '0 : pre_q + 8'h01;
        end
        {stall_carry, stall_d} = {1'b0, stall_q} + {15'h0000, pre_carry};
        if (clear) begin
            stall_d     = '0;
            stall_carry = 1'b0;
        end
        timeout = stall_carry;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ratio_q <= 2'h0;
            pre_q   <= '0;
            stall_q <= '0;
        end else begin
            ratio_q <= ratio_d;
            pre_q   <= pre_d;
            stall_q <= stall_d;
        end
    end
endmodule
`default_nettype wire

//--- bus_error_status_logger.sv
// Bus error status logger: builds the upper fields of the machine-check
// bank status register from bus pins and internal failure indications.
// Assumes internal request inputs are on mclk and bus pins are not.
//
// Functional notes
// - Bus-queue error class held in bits 27:25.
// - Bit 28 set on redundancy check mismatch.
// - Bit 29 set when driving bus error.
// - Bit 30 set when driving bus initialise.
// - Bit 35 set on external bus initialise.
// - Bit 36 set on response code parity error.
// - Response code checked against response parity pin.
// - Bit 37 set on split-access hard error.
// - Bit 38 set on retirement-stall timeout.
// - Stall counter carry out signals timeout.
// - Counter cleared on retire, exception, reset, stall-induced initialise.
// - Counter prescaled by eight-bit divide-by-128 timer.
// - Bus clock is half, third or quarter.
// - Counter increments once per prescaler carry.
// - Set timeout bit kept until a status write clears it.
// - Bit 42 on own hard error, locked.
// - Bit 43 on internal failure, locked.
`default_nettype none
`timescale 1ns/1ns
module bus_error_status_logger (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic [1:0]  bus_ratio,
    input  wire logic        retire_pulse,
    input  wire logic        core_exception,
    input  wire logic        redundancy_check_mismatch,
    input  wire logic        bus_error_req,
    input  wire logic        bus_init_req,
    input  wire logic        internal_failure,
    input  wire logic        bq_err_valid,
    input  wire logic [2:0]  bq_err_class,
    input  wire logic        own_txn_active,
    input  wire logic        split_access_active,
    input  wire logic [2:0]  response_code_lines_n,
    input  wire logic        response_parity_pin_n,
    input  wire logic        response_strobe_n,
    input  wire logic        bus_init_in_n,
    output var  logic        bus_init_out_n,
    output var  logic        bus_init_oe,
    output var  logic        bus_error_signal,
    output var  logic        internal_error_pin,
    output var  logic        retirement_stall,
    input  wire logic        status_wr_en,
    input  wire logic [63:0] status_wr_data,
    output var  logic [63:0] machine_check_bank_status
);
    // ********************************************************************
    // Pin synchronisation
    // ********************************************************************
    logic [bus_error_logger_pkg::SYNC_W-1:0] pins_raw;
    logic [bus_error_logger_pkg::SYNC_W-1:0] pins_sync;
    logic [bus_error_logger_pkg::SYNC_W-1:0] pins_idle;
    logic [2:0]                              resp_code;
    logic                                    resp_par;
    logic                                    resp_strobe;

    assign pins_raw  = {bus_init_in_n, response_strobe_n, response_parity_pin_n, response_code_lines_n};
    assign pins_idle = 6'h3F;

    pin_sync #(
        .W          (bus_error_logger_pkg::SYNC_W)
    ) u_pin_sync (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .pins       (pins_raw),
        .idle_value (pins_idle),
        .stable     (pins_sync)
    );

    assign resp_code   = ~pins_sync[2:0];
    assign resp_par    = ~pins_sync[3];
    assign resp_strobe = ~pins_sync[4];

    // ********************************************************************
    // Stall watchdog
    // ********************************************************************
    logic stall_timeout;
    logic stall_clear;
    logic stall_pin_q;

    // clear on retire, exception, stall-induced initialise
    // The registered timeout marks the stall-induced initialise, which avoids a loop through the counter.
    assign stall_clear = retire_pulse || core_exception || stall_pin_q;

    stall_watchdog u_stall_watchdog (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .bus_ratio (bus_ratio),
        .clear     (stall_clear),
        .bus_tick  (),
        .timeout   (stall_timeout)
    );

    // ********************************************************************
    // Pin drive and event detection
    // ********************************************************************
    logic                                        strobe_q;
    logic                                        strobe_d;
    logic                                        ext_init_q;
    logic                                        ext_init_d;
    logic [3:0]                                  hold_q;
    logic [3:0]                                  hold_d;
    logic [bus_error_logger_pkg::OWN_DRIVE_W-1:0] own_q;
    logic [bus_error_logger_pkg::OWN_DRIVE_W-1:0] own_d;
    logic                                        oe_q;
    logic                                        oe_d;
    logic                                        bus_error_signal_q;
    logic                                        bus_error_signal_d;
    logic                                        internal_error_pin_q;
    logic                                        internal_error_pin_d;
    logic                                        stall_pin_d;
    logic                                        resp_event;
    logic                                        ext_init_event;
    logic                                        ext_asserted;

    always_comb begin
        strobe_d   = resp_strobe;
        resp_event = resp_strobe && !strobe_q;
        // Our own drive echoes back through the synchroniser, so it is masked.
        own_d        = {own_q[bus_error_logger_pkg::OWN_DRIVE_W-2:0], oe_q};
        ext_asserted = (pins_sync[bus_error_logger_pkg::SYNC_W-1] == 1'b0) && (own_q == '0) && !oe_q;
        ext_init_d     = ext_asserted;
        ext_init_event = ext_asserted && !ext_init_q;
        // The initialise pin is held for a fixed count once started.
        hold_d = hold_q;
        if (bus_init_req || stall_timeout) begin
            hold_d = bus_error_logger_pkg::INIT_HOLD_CYCLES;
        end else if (hold_q != 4'h0) begin
            hold_d = hold_q - 4'h1;
        end
        oe_d        = (hold_d != 4'h0);
        bus_error_signal_d      = bus_error_req;
        internal_error_pin_d      = internal_failure;
        stall_pin_d = stall_timeout;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            strobe_q    <= 1'b0;
            ext_init_q  <= 1'b0;
            hold_q      <= 4'h0;
            own_q       <= '0;
            oe_q        <= 1'b0;
            bus_error_signal_q      <= 1'b0;
            internal_error_pin_q      <= 1'b0;
            stall_pin_q <= 1'b0;
        end else begin
            strobe_q    <= strobe_d;
            ext_init_q  <= ext_init_d;
            hold_q      <= hold_d;
            own_q       <= own_d;
            oe_q        <= oe_d;
            bus_error_signal_q      <= bus_error_signal_d;
            internal_error_pin_q      <= internal_error_pin_d;
            stall_pin_q <= stall_pin_d;
        end
    end

    assign bus_init_out_n     = 1'b0;
    assign bus_init_oe        = oe_q;
    assign bus_error_signal   = bus_error_signal_q;
    assign internal_error_pin = internal_error_pin_q;
    assign retirement_stall   = stall_pin_q;

    // ********************************************************************
    // Status register
    // ********************************************************************
    logic [63:0] status_q;
    logic [63:0] status_d;
    logic [63:0] set_vec;
    logic        par_err;
    logic        hard_resp;
    logic        locked;

    always_comb begin
        par_err   = resp_event && ((^resp_code) != resp_par);
        hard_resp = resp_event && !par_err && (resp_code == bus_error_logger_pkg::RESP_HARD_ERROR);
        set_vec   = 64'h0000_0000_0000_0000;
        set_vec[bus_error_logger_pkg::BIT_FRC]        = redundancy_check_mismatch;
        set_vec[bus_error_logger_pkg::BIT_BUS_ERR]    = bus_error_signal_q;
        set_vec[bus_error_logger_pkg::BIT_INT_INIT]   = oe_q;
        set_vec[bus_error_logger_pkg::BIT_EXT_INIT]   = ext_init_event;
        set_vec[bus_error_logger_pkg::BIT_RESP_PAR]   = par_err;
        set_vec[bus_error_logger_pkg::BIT_SPLIT_HARD] = hard_resp && split_access_active;
        set_vec[bus_error_logger_pkg::BIT_STALL]      = stall_timeout;
        set_vec[bus_error_logger_pkg::BIT_HARD_ERR]   = hard_resp && own_txn_active;
        set_vec[bus_error_logger_pkg::BIT_INT_FAIL]   = internal_failure;

        locked = status_q[bus_error_logger_pkg::BIT_STALL] || status_q[bus_error_logger_pkg::BIT_HARD_ERR]
                 || status_q[bus_error_logger_pkg::BIT_INT_FAIL];

        status_d = status_q;
        if (status_wr_en) begin
            status_d = (status_q & status_wr_data & bus_error_logger_pkg::STICKY_MASK)
                       | (status_wr_data & bus_error_logger_pkg::CLASS_MASK);
        end
        if (bq_err_valid && !locked) begin
            status_d[bus_error_logger_pkg::CLASS_MSB:bus_error_logger_pkg::CLASS_LSB] = bq_err_class;
        end
        // Hardware sets win over a clearing write in the same cycle.
        status_d = status_d | set_vec;
        status_d = status_d & bus_error_logger_pkg::IMPL_MASK;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= bus_error_logger_pkg::STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    assign machine_check_bank_status = status_q;
endmodule
`default_nettype wire

//--- bus_error_logger_properties.sv
// Port-level checks of the bus error status logger.
// Assumes it is bound into every instance of the logger.
`timescale 1ns/1ns
`default_nettype none
module bus_error_logger_properties (
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        redundancy_check_mismatch,
    input wire logic        bus_error_req,
    input wire logic        internal_failure,
    input wire logic        bq_err_valid,
    input wire logic [2:0]  bq_err_class,
    input wire logic        status_wr_en,
    input wire logic [63:0] status_wr_data,
    input wire logic        bus_init_oe,
    input wire logic        bus_error_signal,
    input wire logic        internal_error_pin,
    input wire logic        retirement_stall,
    input wire logic [63:0] machine_check_bank_status
);
    wire [63:0] st = machine_check_bank_status;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    a_frc_sets_bit:
    assert property (redundancy_check_mismatch |=> st[28]) else $error("mismatch not logged");
    a_bus_error_signal_drive_copy:
    assert property (bus_error_req |=> bus_error_signal) else $error("bus error not driven");
    a_bus_error_signal_logs_bit:
    assert property (bus_error_signal |-> ##[0:1] st[29]) else $error("bus error not logged");
    a_internal_error_pin_logs_bit:
    assert property (internal_failure |=> internal_error_pin ##[0:1] st[43]) else $error("failure not logged");
    a_init_hold_time:
    assert property ($rose(bus_init_oe) |-> bus_init_oe [*8]) else $error("initialise drive too short");
    a_init_logs_bit:
    assert property (bus_init_oe |-> ##[0:1] st[30]) else $error("own initialise not logged");
    a_reserved_read_zero:
    assert property ((st & ~bus_error_logger_pkg::IMPL_MASK) == 64'h0) else $error("reserved bit set");
    a_write_clears_frc:
    assert property (status_wr_en && !status_wr_data[28] && !redundancy_check_mismatch |=> !st[28])
        else $error("write zero did not clear");
    a_class_loads:
    assert property (bq_err_valid && !st[38] && !st[42] && !st[43] |=> st[27:25] == $past(bq_err_class))
        else $error("class not loaded");
    a_class_locked:
    assert property (bq_err_valid && st[43] && !status_wr_en |=> $stable(st[27:25])) else $error("locked class changed");
    a_stall_one_pulse:
    assert property (retirement_stall |=> !retirement_stall) else $error("stall pulse too long");
    a_stall_logs_bit:
    assert property (retirement_stall |-> ##[0:1] st[38]) else $error("stall not logged");

    cover property (st[36]);
    cover property (st[42] && st[37]);
    cover property ($rose(bus_init_oe));
    cover property (st[35]);
endmodule

bind bus_error_status_logger bus_error_logger_properties u_props (
    .mclk, .reset_n, .redundancy_check_mismatch, .bus_error_req, .internal_failure, .bq_err_valid,
    .bq_err_class, .status_wr_en, .status_wr_data, .bus_init_oe, .bus_error_signal,
    .internal_error_pin, .retirement_stall, .machine_check_bank_status
);
`default_nettype wire

//--- bus_agent_model.sv
// Far-side bus agent: drives one response and shares the initialise wire.
// Assumes go is a one-cycle pulse given while busy is low.
`timescale 1ns/1ns
`default_nettype none
module bus_agent_model (
    input  wire logic       mclk,
    input  wire logic       go,
    input  wire logic [2:0] code,
    input  wire logic       bad_par,
    input  wire logic [2:0] lag,
    input  wire logic       ext_init,
    input  wire logic       bus_init_oe,
    output logic      [2:0] response_code_lines_n,
    output logic            response_parity_pin_n,
    output logic            response_strobe_n,
    output logic            bus_init_in_n,
    output logic            busy
);
    logic [4:0] cnt_q = 5'h00;
    logic [2:0] code_q;
    logic       par_q;
    logic [4:0] beg;
    logic       drive;
    always @(posedge mclk) begin
        if (go && !busy) begin
            cnt_q  <= 5'h01;
            code_q <= code;
            par_q  <= ^code ^ bad_par;
        end else if (busy) begin
            cnt_q <= (cnt_q == 5'h14) ? 5'h00 : cnt_q + 5'h01;
        end
    end
    // Released lines float to their pull-up level, so stale data never lingers.
    assign busy = cnt_q != 5'h00;
    assign beg = 5'h02 + {2'h0, lag};
    assign drive = busy && cnt_q < 5'h11;
    assign response_code_lines_n = drive ? ~code_q : 3'h7;
    assign response_parity_pin_n = drive ? ~par_q : 1'b1;
    assign response_strobe_n = !(cnt_q >= beg && cnt_q < beg + 5'h08);
    assign bus_init_in_n = !(ext_init || bus_init_oe);
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the bus error status logger.
// Assumes the agent model drives the bus pins and the checker is bound.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        mclk = 1'b0;
    logic        reset_n, retire_pulse, core_exception, redundancy_check_mismatch, bus_error_req;
    logic        bus_init_req, internal_failure, bq_err_valid, own_txn_active, split_access_active;
    logic        status_wr_en, go, bad_par, ext_init, busy, response_parity_pin_n, response_strobe_n;
    logic        bus_init_in_n, bus_init_out_n, bus_init_oe, bus_error_signal, internal_error_pin;
    logic        retirement_stall;
    logic [1:0]  bus_ratio;
    logic [2:0]  bq_err_class, code, lag, response_code_lines_n, v;
    logic [63:0] status_wr_data, st, exp, w;
    logic [2:0]  cls [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
    int          fails = 0;
    int          check_count = 0;
    int          i, n;

    bus_error_status_logger uut (
        .mclk, .reset_n, .bus_ratio, .retire_pulse, .core_exception, .redundancy_check_mismatch,
        .bus_error_req, .bus_init_req, .internal_failure, .bq_err_valid, .bq_err_class,
        .own_txn_active, .split_access_active, .response_code_lines_n, .response_parity_pin_n,
        .response_strobe_n, .bus_init_in_n, .bus_init_out_n, .bus_init_oe, .bus_error_signal,
        .internal_error_pin, .retirement_stall, .status_wr_en, .status_wr_data,
        .machine_check_bank_status(st)
    );
    bus_agent_model agent (
        .mclk, .go, .code, .bad_par, .lag, .ext_init, .bus_init_oe, .response_code_lines_n,
        .response_parity_pin_n, .response_strobe_n, .bus_init_in_n, .busy
    );

    always #2 mclk = ~mclk;

    task automatic check(input logic [63:0] got, input logic [63:0] want);
        check_count++;
        if (got !== want) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, want);
        end
    endtask
    task automatic end_of_test();
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [63:0] d);
        @(posedge mclk);
        status_wr_en   <= 1'b1;
        status_wr_data <= d;
        @(posedge mclk);
        status_wr_en   <= 1'b0;
    endtask
    task automatic cls_ev(input logic [2:0] c);
        @(posedge mclk);
        bq_err_valid <= 1'b1;
        bq_err_class <= c;
        @(posedge mclk);
        bq_err_valid <= 1'b0;
        repeat (2) @(negedge mclk);
    endtask
    task automatic lvl(input logic [2:0] e);
        @(posedge mclk);
        {internal_failure, bus_error_req, redundancy_check_mismatch} <= e;
        @(posedge mclk);
        {internal_failure, bus_error_req, redundancy_check_mismatch} <= 3'h0;
        @(negedge mclk);
        check({internal_error_pin, bus_error_signal}, e[2:1]);
        repeat (4) @(posedge mclk);
    endtask
    function automatic logic [63:0] resp_exp(input logic [2:0] c, input logic b, input logic [1:0] os);
        logic [63:0] e;
        logic        hard;
        hard  = (c == bus_error_logger_pkg::RESP_HARD_ERROR) && !b;
        e     = 64'h0;
        e[36] = b;
        e[42] = hard & os[1];
        e[37] = hard & os[0];
        return e;
    endfunction
    task automatic resp(input logic [2:0] c, input logic b, input logic [1:0] os);
        @(posedge mclk);
        {go, code, bad_par, lag} <= {1'b1, c, b, 3'($urandom % 7)};
        {own_txn_active, split_access_active} <= os;
        {retire_pulse, core_exception} <= 2'($urandom);
        @(posedge mclk);
        {go, retire_pulse, core_exception} <= 3'h0;
        @(posedge mclk);
        for (n = 0; n < 40 && busy; n++) @(posedge mclk);
        if (busy) begin
            fails++;
            end_of_test();
        end
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        check(st, resp_exp(c, b, os));
    endtask

    initial begin
        {reset_n, retire_pulse, core_exception, redundancy_check_mismatch, bus_error_req, bus_init_req} = '0;
        {internal_failure, bq_err_valid, own_txn_active, split_access_active, status_wr_en} = '0;
        {go, bad_par, ext_init, bus_ratio, bq_err_class, code, lag} = '0;
        status_wr_data = 64'h0;
        void'($urandom(32'hBBA6E733));
        bus_ratio <= 2'($urandom % 3);
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        check(st, bus_error_logger_pkg::STATUS_RESET);
        check({bus_init_oe, retirement_stall, bus_error_signal, bus_init_out_n}, 4'h0);
        for (i = 0; i < 5; i++) begin
            cls_ev(cls[i]);
            check(st[27:25], cls[i]);
        end
        lvl(3'h4);
        cls_ev(3'h2);
        check(st[27:25], 3'h5);
        wr(64'h0);
        exp = 64'h0;
        for (i = 0; i < 16; i++) begin
            v = 3'($urandom);
            lvl(v);
            exp = exp | (64'(v[2]) << 43) | (64'(v[1]) << 29) | (64'(v[0]) << 28);
            w = (i == 0) ? 64'hFFFF_FFFF_FFFF_FFFF : {$urandom, $urandom};
            wr(w);
            exp = (exp & w & bus_error_logger_pkg::STICKY_MASK) | (w & bus_error_logger_pkg::CLASS_MASK);
            @(negedge mclk);
            check(st, exp);
        end
        wr(64'h0);
        for (i = 0; i < 24; i++) begin
            resp((i < 4) ? 3'h1 : 3'($urandom), (i < 4) ? 1'b0 : 1'($urandom), 2'((i < 4) ? i : $urandom));
            wr(64'h0);
        end
        @(posedge mclk);
        bus_init_req <= 1'b1;
        @(posedge mclk);
        bus_init_req <= 1'b0;
        n = 0;
        repeat (16) begin
            @(negedge mclk);
            n += int'(bus_init_oe);
        end
        check(n, bus_error_logger_pkg::INIT_HOLD_CYCLES);
        check(st, 64'h0000_0000_4000_0000);
        wr(64'h0);
        repeat (6) @(posedge mclk);
        ext_init <= 1'b1;
        repeat (3) @(posedge mclk);
        ext_init <= 1'b0;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        check(st, 64'h0000_0008_0000_0000);
        end_of_test();
    end
endmodule
`default_nettype wire
